// File: rtl/sapc_control.sv
`timescale 1ns/1ps
module sapc_control (
    // clock and reset
    input  wire logic                           core_clk_in,
    input  wire logic                           rst_n_in,
    // host control pins
    input  wire logic                           chip_select_n_in,
    input  wire logic                           read_n_in,
    input  wire logic                           conversion_start_n_in,
    input  wire logic                           power_down_n_in,
    input  wire logic                           shutdown_depth_select_in,
    // comparator decision for the bit under trial, already differential
    input  wire logic                           compare_high_in,
    // analog front end control
    output logic                                sample_hold_out,
    output logic [sapc_pkg::RESULT_WIDTH-1:0]   trial_word_out,
    output sapc_pkg::sapc_power_type            power_mode_out,
    // result port and status
    output logic                                busy_n_out,
    output logic [sapc_pkg::RESULT_WIDTH-1:0]   result_bus_out,
    output logic                                result_bus_oe_out
);
    import sapc_pkg::*;

    sapc_state_type          state;
    sapc_state_type          next_state;
    logic [11:0]             approximation_register;
    logic [11:0]             next_approximation_register;
    logic [11:0]             result_latch;
    logic [11:0]             next_result_latch;
    logic [3:0]              bit_index;
    logic [3:0]              next_bit_index;
    logic [3:0]              step_count;
    logic [3:0]              next_step_count;
    logic                    start_prev;
    logic                    start_fall;
    logic                    step_done;
    logic                    next_start_prev;
    logic [11:0]             trial_bit;
    // assertion helper: length of the current busy span
    logic [4:0]              busy_cycles;
    logic [4:0]              next_busy_cycles;

    function automatic logic [11:0] bit_mask(input logic [3:0] idx);
        bit_mask = 12'h001 << idx;
    endfunction : bit_mask

    // edge is tracked only while selected; a start already low when select falls counts as an edge
    assign start_fall = !chip_select_n_in && start_prev && !conversion_start_n_in;
    assign step_done  = (step_count == 4'h0);
    assign trial_bit  = bit_mask(bit_index);

    // the oscillator is the core clock; no host clock drives conversion
    always_comb begin
        next_state                  = state;
        next_approximation_register = approximation_register;
        next_result_latch           = result_latch;
        next_bit_index              = bit_index;
        next_step_count             = step_count;
        next_start_prev             = chip_select_n_in ? 1'b1 : conversion_start_n_in;
        unique case (state)
            SAPC_IDLE: begin
                if (start_fall && power_mode_out == SAPC_AWAKE) begin
                    next_state                  = SAPC_SAMPLE;
                    next_approximation_register = RESULT_RESET;
                    next_bit_index              = MSB_INDEX;
                    next_step_count             = STEP_COUNT - 4'h1;
                end
            end
            SAPC_SAMPLE: begin
                // one hold instant for both inputs
                next_state                  = SAPC_CONVERT;
                next_approximation_register = bit_mask(MSB_INDEX);
            end
            SAPC_CONVERT: begin
                // start edges are not looked at here
                if (step_done) begin
                    next_step_count = STEP_COUNT - 4'h1;
                    if (!compare_high_in) begin
                        next_approximation_register = approximation_register & ~trial_bit;
                    end
                    if (bit_index == 4'h0) begin
                        next_state        = SAPC_IDLE;
                        next_result_latch = next_approximation_register;
                    end else begin
                        next_bit_index              = bit_index - 4'h1;
                        next_approximation_register = next_approximation_register | bit_mask(bit_index - 4'h1);
                    end
                end else begin
                    next_step_count = step_count - 4'h1;
                end
            end
            default: begin
                next_state = SAPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state                  <= SAPC_IDLE;
            approximation_register <= RESULT_RESET;
            result_latch           <= RESULT_RESET;
            bit_index              <= 4'h0;
            step_count             <= 4'h0;
            start_prev             <= 1'b1;
        end else begin
            state                  <= next_state;
            approximation_register <= next_approximation_register;
            result_latch           <= next_result_latch;
            bit_index              <= next_bit_index;
            step_count             <= next_step_count;
            start_prev             <= next_start_prev;
        end
    end

    // power mode follows pins; a conversion in flight finishes first
    always_comb begin
        if (power_down_n_in || state != SAPC_IDLE) begin
            power_mode_out = SAPC_AWAKE;
        end else if (shutdown_depth_select_in) begin
            power_mode_out = SAPC_NAP;
        end else begin
            power_mode_out = SAPC_SLEEP;
        end
    end

    assign busy_n_out        = (state == SAPC_IDLE);
    assign sample_hold_out   = (state == SAPC_IDLE);
    assign trial_word_out    = approximation_register;
    assign result_bus_out    = result_latch;
    assign result_bus_oe_out = !read_n_in && !chip_select_n_in;

    property p_oe_follows_pins;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        result_bus_oe_out == (!read_n_in && !chip_select_n_in);
    endproperty
    a_oe_follows_pins: assert property (p_oe_follows_pins) else $error("output enable wrong");

    property p_start_begins;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state == SAPC_IDLE && start_fall && power_down_n_in) |=> !busy_n_out;
    endproperty
    a_start_begins: assert property (p_start_begins) else $error("start edge missed");

    property p_unselected_ignored;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state == SAPC_IDLE && chip_select_n_in) |=> busy_n_out;
    endproperty
    a_unselected_ignored: assert property (p_unselected_ignored) else $error("start without select");

    property p_cleared_at_start;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state == SAPC_IDLE && next_state == SAPC_SAMPLE) |=> approximation_register == 12'h000;
    endproperty
    a_cleared_at_start: assert property (p_cleared_at_start) else $error("register not cleared");

    property p_no_restart;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state == SAPC_CONVERT && start_fall) |=> (state != SAPC_SAMPLE);
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("conversion restarted");

    property p_msb_first;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state == SAPC_SAMPLE) |=> (bit_index == MSB_INDEX);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

    property p_latch_on_end;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(busy_n_out) |-> result_bus_out == $past(next_result_latch);
    endproperty
    a_latch_on_end: assert property (p_latch_on_end) else $error("result not latched");

    property p_result_held;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (busy_n_out && $past(busy_n_out)) |-> $stable(result_bus_out);
    endproperty
    a_result_held: assert property (p_result_held) else $error("result changed while idle");

    property p_nap_mode;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state == SAPC_IDLE && !power_down_n_in) |->
            power_mode_out == (shutdown_depth_select_in ? SAPC_NAP : SAPC_SLEEP);
    endproperty
    a_nap_mode: assert property (p_nap_mode) else $error("shutdown mode wrong");

    property p_busy_length;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $fell(busy_n_out) |-> !busy_n_out [*8];
    endproperty
    a_busy_length: assert property (p_busy_length) else $error("busy too short");

    // counts busy-low cycles; it wraps after 31, which only a stuck conversion reaches
    always_comb begin
        next_busy_cycles = busy_n_out ? 5'h00 : busy_cycles + 5'h01;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_cycles <= 5'h00;
        end else begin
            busy_cycles <= next_busy_cycles;
        end
    end

    // one sample cycle plus one cycle per bit decision
    property p_busy_span;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(busy_n_out) |-> busy_cycles == 5'(1 + RESULT_WIDTH * STEP_COUNT);
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span wrong");

    // a taken start opens with one sample cycle and then the msb trial
    sequence s_start_taken;
        state == SAPC_IDLE && start_fall && power_down_n_in;
    endsequence

    sequence s_sample_step;
        state == SAPC_SAMPLE && !sample_hold_out && approximation_register == RESULT_RESET;
    endsequence

    sequence s_msb_trial;
        state == SAPC_CONVERT && bit_index == MSB_INDEX && trial_word_out == bit_mask(MSB_INDEX);
    endsequence

    property p_conversion_opens;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        s_start_taken |=> s_sample_step ##1 s_msb_trial;
    endproperty
    a_conversion_opens: assert property (p_conversion_opens) else $error("conversion opened wrongly");

    property p_sample_one_cycle;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state == SAPC_SAMPLE) |=> (state == SAPC_CONVERT && !sample_hold_out);
    endproperty
    a_sample_one_cycle: assert property (p_sample_one_cycle) else $error("sample step wrong");

    property p_hold_on_start;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $fell(busy_n_out) |-> $fell(sample_hold_out);
    endproperty
    a_hold_on_start: assert property (p_hold_on_start) else $error("hold not taken at start");

    // each decision step keeps or drops the trial bit, then tries the next lower one unless it was bit 0
    sequence s_decide_step;
        state == SAPC_CONVERT && step_done;
    endsequence

    property p_keep_when_high;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (s_decide_step ##0 compare_high_in) |=> (approximation_register & $past(trial_bit)) == $past(trial_bit);
    endproperty
    a_keep_when_high: assert property (p_keep_when_high) else $error("kept bit lost");

    property p_clear_when_low;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (s_decide_step ##0 !compare_high_in) |=> (approximation_register & $past(trial_bit)) == 12'h000;
    endproperty
    a_clear_when_low: assert property (p_clear_when_low) else $error("dropped bit kept");

    property p_bit_order;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (s_decide_step ##0 (bit_index != 4'h0)) |=> (state == SAPC_CONVERT && bit_index == $past(bit_index) - 4'h1);
    endproperty
    a_bit_order: assert property (p_bit_order) else $error("bit order wrong");

    property p_last_bit_ends;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (s_decide_step ##0 (bit_index == 4'h0)) |=> (busy_n_out && result_bus_out == approximation_register);
    endproperty
    a_last_bit_ends: assert property (p_last_bit_ends) else $error("conversion end wrong");

    // the result latch moves only on the final decision
    property p_latch_only_at_end;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state != SAPC_CONVERT || !step_done || bit_index != 4'h0) |=> $stable(result_bus_out);
    endproperty
    a_latch_only_at_end: assert property (p_latch_only_at_end) else $error("result moved early");

    property p_result_steady_busy;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !busy_n_out |=> (busy_n_out || $stable(result_bus_out));
    endproperty
    a_result_steady_busy: assert property (p_result_steady_busy) else $error("result moved while busy");

    // shutdown refuses starts, and never cuts a running conversion
    property p_shutdown_refuses;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state == SAPC_IDLE && !power_down_n_in) |=> busy_n_out;
    endproperty
    a_shutdown_refuses: assert property (p_shutdown_refuses) else $error("start taken in shutdown");

    property p_awake_while_busy;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !busy_n_out |-> power_mode_out == SAPC_AWAKE;
    endproperty
    a_awake_while_busy: assert property (p_awake_while_busy) else $error("shutdown during conversion");

    property p_bus_released;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (chip_select_n_in || read_n_in) |-> !result_bus_oe_out;
    endproperty
    a_bus_released: assert property (p_bus_released) else $error("bus driven while released");
endmodule : sapc_control

// File: rtl/sapc_pkg.sv
package sapc_pkg;
    localparam int          RESULT_WIDTH   = 12;
    localparam int          CLK_PERIOD_NS  = 50;
    // conversion time as printed, split over the bit decisions
    localparam int          CONV_TIME_NS   = 700;
    localparam int          STEP_CYCLES    = (CONV_TIME_NS / RESULT_WIDTH) / CLK_PERIOD_NS;
    localparam logic [3:0]  STEP_COUNT     = 4'(STEP_CYCLES < 1 ? 1 : STEP_CYCLES);
    localparam logic [3:0]  MSB_INDEX      = 4'hb;
    localparam logic [11:0] RESULT_RESET   = 12'h000;

    typedef enum logic [2:0] {
        SAPC_IDLE     = 3'b001,
        SAPC_SAMPLE   = 3'b010,
        SAPC_CONVERT  = 3'b100
    } sapc_state_type;

    typedef enum logic [1:0] {
        SAPC_AWAKE    = 2'b00,
        SAPC_NAP      = 2'b01,
        SAPC_SLEEP    = 2'b10
    } sapc_power_type;
endpackage : sapc_pkg

// File: tb/sapc_cmp_model.sv
`timescale 1ns/1ps
module sapc_cmp_model (
    // converter side
    input  wire logic        sample_hold_in,
    input  wire logic [11:0] trial_word_in,
    // analog sources given as codes
    input  wire logic [11:0] positive_analog_in,
    input  wire logic [11:0] negative_analog_in,
    // decision for the bit under trial
    output logic             compare_high_out
);
    logic [11:0] held;

    // both inputs captured together while tracking, frozen on hold
    always_latch begin
        if (sample_hold_in) begin
            held <= positive_analog_in - negative_analog_in;
        end
    end

    assign compare_high_out = (trial_word_in <= held);
endmodule : sapc_cmp_model

// File: tb/test_sar_adc_parallel_control.sv
`timescale 1ns/1ps
module test_sar_adc_parallel_control;
    import sapc_pkg::*;
    logic           clk = 0;
    logic           rst_n = 0;
    logic           cs_n = 1;
    logic           rd_n = 1;
    logic           st_n = 1;
    logic           pd_n = 1;
    logic           dsel = 0;
    logic           cmp;
    logic           sh;
    logic           busy_n;
    logic           oe;
    logic [11:0]    trial;
    logic [11:0]    res;
    logic [11:0]    pos = 12'h000;
    logic [11:0]    neg = 12'h000;
    sapc_power_type mode;
    int             error_cnt = 0;
    int             tests_run = 0;

    always #25 clk = ~clk;

    sapc_control DUT (.core_clk_in(clk), .rst_n_in(rst_n), .chip_select_n_in(cs_n), .read_n_in(rd_n),
        .conversion_start_n_in(st_n), .power_down_n_in(pd_n), .shutdown_depth_select_in(dsel),
        .compare_high_in(cmp), .sample_hold_out(sh), .trial_word_out(trial), .power_mode_out(mode),
        .busy_n_out(busy_n), .result_bus_out(res), .result_bus_oe_out(oe));
    sapc_cmp_model cmp_model (.sample_hold_in(sh), .trial_word_in(trial), .positive_analog_in(pos),
        .negative_analog_in(neg), .compare_high_out(cmp));

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    task automatic read_back(input logic [11:0] exp);
        @(posedge clk);
        cs_n <= 0;
        rd_n <= 0;
        @(posedge clk);
        #1 chk(12'(oe), 12'h001, "read drive");
        chk(res, exp, "result word");
        @(posedge clk);
        rd_n <= 1;
        #1 chk(12'(oe), 12'h000, "read release");
    endtask : read_back

    // the analog input moves mid-conversion; the held sample must win
    task automatic conv(input logic [11:0] p, input logic [11:0] q, input bit poke);
        int n;
        repeat (4) @(posedge clk);
        pos <= p;
        neg <= q;
        cs_n <= 0;
        @(posedge clk);
        st_n <= 0;
        @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            if (n == 3) pos <= ~p;
            if (n == 3 && poke) st_n <= 1;
            if (n == 5) st_n <= 0;
            #1 n++;
        end while (busy_n === 1'b0 && n < 40);
        chk(12'(n), 12'(1 + RESULT_WIDTH * STEP_COUNT), "busy span");
        chk(res, p - q, "result at busy rise");
        @(posedge clk);
        st_n <= 1;
        read_back(p - q);
        read_back(p - q);
        $display("conversion test done");
    endtask : conv

    task automatic unselected;
        @(posedge clk);
        cs_n <= 1;
        st_n <= 0;
        rd_n <= 0;
        repeat (3) @(posedge clk);
        #1 chk(12'(busy_n), 12'h001, "start while unselected");
        chk(12'(oe), 12'h000, "read while unselected");
        @(posedge clk);
        st_n <= 1;
        rd_n <= 1;
        $display("unselected test done");
    endtask : unselected

    task automatic power;
        @(posedge clk);
        cs_n <= 0;
        dsel <= 1;
        pd_n <= 0;
        @(posedge clk);
        #1 chk(12'(mode), 12'(SAPC_NAP), "nap mode");
        @(posedge clk);
        dsel <= 0;
        st_n <= 0;
        repeat (3) @(posedge clk);
        #1 chk(12'(mode), 12'(SAPC_SLEEP), "sleep mode");
        chk(12'(busy_n), 12'h001, "start in shutdown");
        @(posedge clk);
        pd_n <= 1;
        st_n <= 1;
        #1 chk(12'(mode), 12'(SAPC_AWAKE), "awake");
        $display("power test done");
    endtask : power

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        conv(12'hfff, 12'h000, 0);
        conv(12'h000, 12'h000, 1);
        conv(12'hc3a, 12'h41f, 0);
        unselected();
        power();
        conv(12'h801, 12'h001, 0);
        print_verdict();
    end

    // over thirty times the expected run length
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
endmodule : test_sar_adc_parallel_control
